//--- include/poi_map.svh
`ifndef POI_MAP_SVH
`define POI_MAP_SVH
// Register byte offsets
`define POI_A_CTRL 8'h00
`define POI_A_PARAM 8'h04
`define POI_A_MAXX 8'h08
`define POI_A_MAXY 8'h0c
`define POI_A_TMO 8'h10
`define POI_A_INSTR 8'h14
`define POI_A_OPX 8'h18
`define POI_A_OPY 8'h1c
`define POI_A_OPF 8'h20
`define POI_A_DADR 8'h24
`define POI_A_DDAT 8'h28
`define POI_A_STAT 8'h2c
`define POI_A_POSX 8'h30
`define POI_A_POSY 8'h34
`define POI_A_SPD 8'h38
`define POI_A_OFFX 8'h3c
`define POI_A_OFFY 8'h40
// Index register window, 0x80 to 0xbc
`define POI_IDX_WIN 2'h2
// Control and parameter fields
`define POI_CT_TWO 0
`define POI_CT_CLR 1
`define POI_PR_UNIT 0
`define POI_PR_MCU_HI 2
`define POI_PR_MCU_LO 1
// Instruction word fields
`define POI_IN_CODE_HI 7
`define POI_IN_OMIT 8
`define POI_IN_SCHK 9
// Operand word fields
`define POI_OP_PRES 31
`define POI_OP_MODE_HI 30
`define POI_OP_MODE_LO 29
`define POI_OP_IDXEN 28
`define POI_OP_ISEL_HI 27
`define POI_OP_ISEL_LO 24
`define POI_OP_LIT_HI 20
`define POI_OP_REG_HI 12
// Reset values
`define POI_RST_CTRL 32'h00000001
`define POI_RST_TMO 32'h00000000
// Instruction codes
`define POI_COD_DRIVE 8'h00
`define POI_COD_LINEAR 8'h01
`define POI_COD_ARC_CLOCKWISE 8'h02
`define POI_COD_ARC_COUNTER 8'h03
`define POI_COD_DWELL 8'h04
`define POI_COD_SERVO_CHECK 8'h09
`define POI_COD_ZERO_RET 8'h1c
`define POI_COD_SET_ORIGIN 8'h1d
`define POI_COD_INT_DRIVE 8'h1f
`define POI_COD_OFFSET 8'h49
`define POI_COD_ABSOLUTE 8'h5a
`define POI_COD_INCREMENTAL 8'h5b
`define POI_COD_SET_POS 8'h5c
// Operand limits: 999999, D6999, hole D2000..D3999, 7000 registers
`define POI_LIT_MAX 32'sh000f423f
`define POI_REG_MAX 32'sh00001b57
`define POI_HOLE_LO 32'sh000007d0
`define POI_HOLE_HI 32'sh00000f9f
`define POI_REG_CNT 13'h1b58
// Speed caps: 200 kHz, 100 kHz interpolating
`define POI_SPD_CAP 32'sh00030d40
`define POI_SPD_CAP_INTERP 32'sh000186a0
// Scale factors 1, 10, 100, 1000
`define POI_MUL1 32'sh00000001
`define POI_MUL10 32'sh0000000a
`define POI_MUL100 32'sh00000064
`define POI_MUL1000 32'sh000003e8
// Servo end error code 4002
`define POI_ERR_SERVO 16'h0fa2
// Timing: 250 MHz clock, 10 ms dwell unit
`define POI_CLK_MHZ 32'h000000fa
`define POI_HZ_PER_MHZ 32'h000f4240
`define POI_DWELL_MS 32'h0000000a
`define POI_US_PER_MS 32'h000003e8
`endif

//--- include/poi_pkg.sv
package poi_pkg;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FX,
		ST_FY,
		ST_FF,
		ST_EXEC,
		ST_MOVE,
		ST_DWELL,
		ST_SERVO
	} poi_state_type;
	// Operand addressing modes
	typedef enum logic [1:0] {
		OPM_LIT,
		OPM_DREG16,
		OPM_DREG32,
		OPM_RSVD
	} poi_opm_type;
endpackage

//--- verilog/poi_operand_fetch.sv
`include "poi_map.svh"

module poi_operand_fetch
	import poi_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic one_axis,
	input wire logic d_we,
	input wire logic [12:0] d_adr,
	input wire logic [15:0] d_wdata,
	output logic [15:0] d_rdata,
	input wire logic x_we,
	input wire logic [3:0] x_sel,
	input wire logic [31:0] x_wdata,
	output logic [31:0] x_rdata,
	input wire logic [31:0] op_word,
	output logic signed [31:0] op_val,
	output logic op_bad
);
	// Data registers
	logic [15:0] dreg_r [0:`POI_REG_CNT-1];
	// Index registers: 16-bit group first, 32-bit group second
	logic [31:0] idx_r [0:15];
	logic signed [31:0] op_val_r;
	logic op_bad_r;

	// Index register writes, short ones sign-extended
	for (genvar i = 0; i < 16; i++) begin : g_idx
		always_ff @(posedge mclk) begin
			if (rst) begin
				idx_r[i] <= '0;
			end else if (ce && x_we && x_sel == 4'(i)) begin
				idx_r[i] <= (i < 8) ? {{16{x_wdata[15]}}, x_wdata[15:0]} : x_wdata;
			end
		end
	end

	// Data register write port
	always_ff @(posedge mclk) begin
		if (ce && d_we && d_adr < `POI_REG_CNT) begin
			dreg_r[d_adr] <= d_wdata;
		end
	end

	assign d_rdata = (d_adr < `POI_REG_CNT) ? dreg_r[d_adr] : '0;
	assign x_rdata = idx_r[x_sel];

	// Operand decode
	wire poi_opm_type mode = poi_opm_type'(op_word[`POI_OP_MODE_HI:`POI_OP_MODE_LO]);
	wire logic [3:0] isel = op_word[`POI_OP_ISEL_HI:`POI_OP_ISEL_LO];
	wire logic signed [31:0] ival = op_word[`POI_OP_IDXEN] ? $signed(idx_r[isel]) : '0;
	wire logic signed [31:0] ra = $signed({19'h0, op_word[`POI_OP_REG_HI:0]}) + ival;
	wire logic dbl = mode == OPM_DREG32;
	wire logic signed [31:0] rb = dbl ? ra + `POI_MUL1 : ra;
	// Missing bank on the one-axis variant
	wire logic hole_a = ra >= `POI_HOLE_LO && ra <= `POI_HOLE_HI;
	wire logic hole_b = rb >= `POI_HOLE_LO && rb <= `POI_HOLE_HI;
	wire logic rbad = ra < 0 || rb > `POI_REG_MAX || (one_axis && (hole_a || hole_b));
	wire logic [12:0] ia = rbad ? '0 : ra[12:0];
	wire logic [12:0] ib = rbad ? '0 : rb[12:0];
	wire logic signed [31:0] lit = {{11{op_word[`POI_OP_LIT_HI]}}, op_word[`POI_OP_LIT_HI:0]};
	wire logic lbad = lit > `POI_LIT_MAX || lit < -`POI_LIT_MAX;
	// Register contents, low word at named register
	wire logic signed [31:0] rv = dbl ? $signed({dreg_r[ib], dreg_r[ia]}) :
		$signed({{16{dreg_r[ia][15]}}, dreg_r[ia]});

	// Resolved value, one cycle after the word
	always_ff @(posedge mclk) begin
		if (rst) begin
			op_val_r <= '0;
			op_bad_r <= 1'b0;
		end else if (ce) begin
			op_val_r <= (mode == OPM_LIT) ? lit : rv;
			op_bad_r <= (mode == OPM_LIT) ? lbad : (mode == OPM_RSVD || rbad);
		end
	end

	assign op_val = op_val_r;
	assign op_bad = op_bad_r;
endmodule

//--- verilog/poi_interpreter.sv
`include "poi_map.svh"

// Summary of operation
// - Reject speed above maximum and model cap
// - Travel units and scaling follow parameters
// - Register operands read at execution time
// - Double reference: named low, next high
// - Indexed reference adds index register contents
// - Eight 16-bit and eight 32-bit index registers
// - Omitted drive speed uses axis maximum
// - Operand-only line repeats last group A code
// - One-shot codes need explicit code, one line
// - Travel offset persists until rewritten
// - Absolute and incremental addressing are modal
// - Flagged drive waits for servo completion
// - Servo timeout raises code 4002, stops
// - Zero timeout parameter skips servo check
// - Servo check code waits on demand
// - Drive moves axes independently; one-axis X only
// - Literal and register operand ranges enforced
// - Omitted travel operand leaves axis still
// - Omitted later speed keeps previous value (speed register only; drive steps at axis maximum)

module poi_interpreter
	import poi_pkg::*;
#(
	// Cycles in one dwell unit
	parameter logic [31:0] DWELL_CYC = `POI_DWELL_MS * `POI_US_PER_MS * `POI_CLK_MHZ
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic servo_done,
	output logic busy,
	output logic stopped,
	output logic step_x,
	output logic dir_x,
	output logic step_y,
	output logic dir_y
);
	// Step accumulator wraps at the clock rate
	localparam logic signed [31:0] STEP_HZ = `POI_CLK_MHZ * `POI_HZ_PER_MHZ;

	// Configuration registers
	logic [31:0] ctrl_r;
	logic [31:0] param_r;
	logic signed [31:0] maxs_r [2];
	logic [31:0] tmo_r;
	logic [31:0] opx_r;
	logic [31:0] opy_r;
	logic [31:0] opf_r;
	logic [12:0] dadr_r;
	// Status and modal state
	logic op_err_r;
	logic srv_err_r;
	logic stop_r;
	logic [15:0] err_code_r;
	logic abs_r;
	logic [7:0] last_a_r;
	logic [7:0] code_r;
	logic chk_r;
	logic signed [31:0] spd_last_r;
	// Sequencer
	poi_state_type state_r;
	poi_state_type state_nxt;
	logic [31:0] cnt_r;
	logic signed [31:0] kcnt_r;
	// Captured travel operands
	logic signed [31:0] val_r [2];
	logic bad_r [2];
	// Bus read path
	logic [31:0] prdata_r;
	logic pslverr_r;
	// Servo pin synchroniser
	logic srv_m_r;
	logic srv_s_r;
	// Per-axis views
	wire logic signed [31:0] pos_w [2];
	wire logic signed [31:0] off_w [2];
	wire logic at_w [2];
	wire logic step_w [2];
	wire logic dir_w [2];
	// Resolver port
	wire logic [15:0] d_rdata;
	wire logic [31:0] x_rdata;
	wire logic signed [31:0] op_val;
	wire logic op_bad;

	// Group A membership
	function automatic logic poi_grp_a(input logic [7:0] c);
		poi_grp_a = c == `POI_COD_DRIVE || c == `POI_COD_LINEAR || c == `POI_COD_ARC_CLOCKWISE ||
			c == `POI_COD_ARC_COUNTER || c == `POI_COD_INT_DRIVE;
	endfunction

	// Unit scaling of a travel value
	function automatic logic signed [31:0] poi_scale(input logic signed [31:0] v, input logic [31:0] p);
		logic signed [31:0] m;
		case (p[`POI_PR_MCU_HI:`POI_PR_MCU_LO])
			2'h0: m = `POI_MUL1;
			2'h1: m = `POI_MUL10;
			2'h2: m = `POI_MUL100;
			default: m = `POI_MUL1000;
		endcase
		poi_scale = p[`POI_PR_UNIT] ? v * m : v;
	endfunction

	// Servo completion pin, two stages
	always_ff @(posedge mclk) begin
		if (rst) begin
			srv_m_r <= 1'b0;
			srv_s_r <= 1'b0;
		end else if (ce) begin
			srv_m_r <= servo_done;
			srv_s_r <= srv_m_r;
		end
	end

	// Bus decode
	wire logic two = ctrl_r[`POI_CT_TWO];
	wire logic setup = psel & ~penable;
	wire logic wr = psel & penable & ce & pwrite & ~pslverr_r;
	wire logic h_ctrl = paddr == `POI_A_CTRL;
	wire logic h_param = paddr == `POI_A_PARAM;
	wire logic h_maxx = paddr == `POI_A_MAXX;
	wire logic h_maxy = paddr == `POI_A_MAXY;
	wire logic h_tmo = paddr == `POI_A_TMO;
	wire logic h_instr = paddr == `POI_A_INSTR;
	wire logic h_opx = paddr == `POI_A_OPX;
	wire logic h_opy = paddr == `POI_A_OPY;
	wire logic h_opf = paddr == `POI_A_OPF;
	wire logic h_dadr = paddr == `POI_A_DADR;
	wire logic h_ddat = paddr == `POI_A_DDAT;
	wire logic h_stat = paddr == `POI_A_STAT;
	wire logic h_posx = paddr == `POI_A_POSX;
	wire logic h_posy = paddr == `POI_A_POSY;
	wire logic h_spd = paddr == `POI_A_SPD;
	wire logic h_offx = paddr == `POI_A_OFFX;
	wire logic h_offy = paddr == `POI_A_OFFY;
	wire logic h_idx = paddr[7:6] == `POI_IDX_WIN;
	wire logic ro = h_stat | h_posx | h_posy | h_spd | h_offx | h_offy;
	wire logic mapped = ro | h_ctrl | h_param | h_maxx | h_maxy | h_tmo | h_instr | h_opx |
		h_opy | h_opf | h_dadr | h_ddat | h_idx;
	// Launch and operand writes refused while running or stopped
	wire logic refuse = pwrite & (ro | ((h_instr | h_opx | h_opy | h_opf) & (busy | stop_r)));
	wire logic start = wr & h_instr;
	wire logic clr = wr & h_ctrl & pwdata[`POI_CT_CLR];
	// Status word: code, wait, mode, stop, servo error, operand error, busy
	wire logic [31:0] stat = {err_code_r, 10'h0, state_r == ST_SERVO, abs_r, stop_r, srv_err_r, op_err_r, busy};
	wire logic [31:0] rd_mux = h_ctrl ? ctrl_r : h_param ? param_r : h_maxx ? maxs_r[0] :
		h_maxy ? maxs_r[1] : h_tmo ? tmo_r : h_instr ? {24'h0, code_r} : h_opx ? opx_r :
		h_opy ? opy_r : h_opf ? opf_r : h_dadr ? {19'h0, dadr_r} : h_ddat ? {16'h0, d_rdata} :
		h_stat ? stat : h_posx ? pos_w[0] : h_posy ? pos_w[1] : h_spd ? spd_last_r :
		h_offx ? off_w[0] : h_offy ? off_w[1] : x_rdata;

	// Read data and error captured in the setup cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end else if (ce && setup) begin
			prdata_r <= mapped ? rd_mux : '0;
			pslverr_r <= ~mapped | refuse;
		end
	end

	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign pready = ce;

	// Configuration writes
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_r <= `POI_RST_CTRL;
			param_r <= '0;
			maxs_r[0] <= `POI_SPD_CAP;
			maxs_r[1] <= `POI_SPD_CAP;
			tmo_r <= `POI_RST_TMO;
			opx_r <= '0;
			opy_r <= '0;
			opf_r <= '0;
			dadr_r <= '0;
		end else if (wr) begin
			if (h_ctrl) ctrl_r <= {30'h0, 1'b0, pwdata[`POI_CT_TWO]};
			if (h_param) param_r <= pwdata;
			if (h_maxx) maxs_r[0] <= pwdata;
			if (h_maxy) maxs_r[1] <= pwdata;
			if (h_tmo) tmo_r <= pwdata;
			if (h_opx) opx_r <= pwdata;
			if (h_opy) opy_r <= pwdata;
			if (h_opf) opf_r <= pwdata;
			if (h_dadr) dadr_r <= pwdata[12:0];
		end
	end

	// Resolver sees X, then Y, then speed
	wire logic [31:0] op_word = (state_r == ST_FX) ? opx_r : (state_r == ST_FY) ? opy_r : opf_r;

	poi_operand_fetch u_fetch (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.one_axis(~two),
		.d_we(wr & h_ddat),
		.d_adr(dadr_r),
		.d_wdata(pwdata[15:0]),
		.d_rdata(d_rdata),
		.x_we(wr & h_idx),
		.x_sel(paddr[5:2]),
		.x_wdata(pwdata),
		.x_rdata(x_rdata),
		.op_word(op_word),
		.op_val(op_val),
		.op_bad(op_bad)
	);

	// Instruction decode in the execute cycle
	wire logic ex = state_r == ST_EXEC;
	wire logic pres [2];
	assign pres[0] = opx_r[`POI_OP_PRES];
	assign pres[1] = opy_r[`POI_OP_PRES] & two;
	wire logic pf = opf_r[`POI_OP_PRES];
	wire logic is_a = poi_grp_a(code_r);
	wire logic is_drive = code_r == `POI_COD_DRIVE;
	wire logic is_zret = code_r == `POI_COD_ZERO_RET;
	wire logic is_dwell = code_r == `POI_COD_DWELL;
	wire logic is_schk = code_r == `POI_COD_SERVO_CHECK;
	wire logic is_setp = code_r == `POI_COD_SET_ORIGIN || code_r == `POI_COD_SET_POS;
	wire logic is_off = code_r == `POI_COD_OFFSET;
	wire logic interp = two && (code_r == `POI_COD_LINEAR || code_r == `POI_COD_ARC_CLOCKWISE ||
		code_r == `POI_COD_ARC_COUNTER);
	wire logic signed [31:0] cap = interp ? `POI_SPD_CAP_INTERP : `POI_SPD_CAP;
	// Speed limits; zero speed would never finish
	wire logic spd_bad = pf && (op_val > cap || op_val > maxs_r[0] || (two && op_val > maxs_r[1]) ||
		op_val <= 0);
	wire logic opnd_bad = (pres[0] & bad_r[0]) | (pres[1] & bad_r[1]) | (pf & op_bad);
	wire logic ex_err = ex && (opnd_bad || (is_a && spd_bad) || (is_dwell && !pres[0]));
	wire logic go = ex & ~ex_err;
	wire logic go_move = go & (is_drive | is_zret);
	wire logic all_at = at_w[0] & at_w[1];
	wire logic chk_on = tmo_r != '0;
	wire logic tmo_hit = cnt_r == tmo_r - 32'h1;
	wire logic dw_wrap = cnt_r == DWELL_CYC - 32'h1;

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start) state_nxt = ST_FX;
			end
			ST_FX: state_nxt = ST_FY;
			ST_FY: state_nxt = ST_FF;
			ST_FF: state_nxt = ST_EXEC;
			ST_EXEC: begin
				if (ex_err) begin
					state_nxt = ST_IDLE;
				end else if (is_drive || is_zret) begin
					state_nxt = ST_MOVE;
				end else if (is_dwell && val_r[0] > 0) begin
					state_nxt = ST_DWELL;
				end else if (is_schk && chk_on) begin
					state_nxt = ST_SERVO;
				end else begin
					state_nxt = ST_IDLE;
				end
			end
			ST_MOVE: begin
				if (all_at) state_nxt = (chk_r && chk_on) ? ST_SERVO : ST_IDLE;
			end
			ST_DWELL: begin
				if (dw_wrap && kcnt_r == 32'sh1) state_nxt = ST_IDLE;
			end
			ST_SERVO: begin
				if (srv_s_r || tmo_hit) state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// State, cycle counter, dwell units
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			kcnt_r <= '0;
		end else if (ce) begin
			state_r <= state_nxt;
			// Only the dwell wraps its count; the servo timeout must run its full length
			cnt_r <= (state_nxt != state_r || (state_r == ST_DWELL && dw_wrap)) ? '0 : cnt_r + 32'h1;
			if (go && is_dwell) kcnt_r <= val_r[0];
			else if (state_r == ST_DWELL && dw_wrap) kcnt_r <= kcnt_r - 32'sh1;
		end
	end

	// Code latch with group A repeat
	always_ff @(posedge mclk) begin
		if (rst) begin
			code_r <= `POI_COD_DRIVE;
			chk_r <= 1'b0;
			last_a_r <= `POI_COD_DRIVE;
		end else if (start) begin
			code_r <= pwdata[`POI_IN_OMIT] ? last_a_r : pwdata[`POI_IN_CODE_HI:0];
			chk_r <= pwdata[`POI_IN_SCHK];
			if (!pwdata[`POI_IN_OMIT] && poi_grp_a(pwdata[`POI_IN_CODE_HI:0])) begin
				last_a_r <= pwdata[`POI_IN_CODE_HI:0];
			end
		end
	end

	// Operand capture, X then Y
	always_ff @(posedge mclk) begin
		if (rst) begin
			val_r[0] <= '0;
			val_r[1] <= '0;
			bad_r[0] <= 1'b0;
			bad_r[1] <= 1'b0;
		end else if (ce) begin
			if (state_r == ST_FY) begin
				val_r[0] <= op_val;
				bad_r[0] <= op_bad;
			end
			if (state_r == ST_FF) begin
				val_r[1] <= op_val;
				bad_r[1] <= op_bad;
			end
		end
	end

	// Modal state, speed memory and error flags
	always_ff @(posedge mclk) begin
		if (rst) begin
			abs_r <= 1'b0;
			spd_last_r <= `POI_SPD_CAP;
			op_err_r <= 1'b0;
			srv_err_r <= 1'b0;
			stop_r <= 1'b0;
			err_code_r <= '0;
		end else if (ce) begin
			if (go && code_r == `POI_COD_ABSOLUTE) abs_r <= 1'b1;
			if (go && code_r == `POI_COD_INCREMENTAL) abs_r <= 1'b0;
			if (go && is_a && pf) spd_last_r <= op_val;
			// Error set wins over a clear in the same cycle
			if (ex_err) op_err_r <= 1'b1;
			else if (clr) op_err_r <= 1'b0;
			if (state_r == ST_SERVO && tmo_hit && !srv_s_r) begin
				srv_err_r <= 1'b1;
				stop_r <= 1'b1;
				err_code_r <= `POI_ERR_SERVO;
			end else if (clr) begin
				srv_err_r <= 1'b0;
				stop_r <= 1'b0;
				err_code_r <= '0;
			end
		end
	end

	// Per-axis target, speed and stepping
	for (genvar i = 0; i < 2; i++) begin : g_axis
		logic signed [31:0] pos_r;
		logic signed [31:0] tgt_r;
		logic signed [31:0] off_r;
		logic signed [31:0] vel_r;
		logic signed [31:0] acc_r;
		logic step_r;
		logic dir_r;
		wire logic signed [31:0] sc = poi_scale(val_r[i], param_r);
		// Absolute from zero, incremental from present position
		wire logic signed [31:0] tgt = pres[i] ? (abs_r ? sc : pos_r + sc) + off_r : pos_r;
		wire logic signed [31:0] sum = acc_r + vel_r;
		wire logic run = state_r == ST_MOVE && pos_r != tgt_r;
		wire logic step = run && sum >= STEP_HZ;

		always_ff @(posedge mclk) begin
			if (rst) begin
				pos_r <= '0;
				tgt_r <= '0;
				off_r <= '0;
				vel_r <= '0;
				acc_r <= '0;
				step_r <= 1'b0;
				dir_r <= 1'b0;
			end else if (ce) begin
				step_r <= step;
				if (go_move) begin
					tgt_r <= is_zret ? '0 : tgt;
					vel_r <= (is_zret || !pf) ? maxs_r[i] : op_val;
					acc_r <= '0;
				end else if (run) begin
					acc_r <= step ? sum - STEP_HZ : sum;
				end
				if (step) begin
					pos_r <= (tgt_r < pos_r) ? pos_r - `POI_MUL1 : pos_r + `POI_MUL1;
					dir_r <= tgt_r < pos_r;
				end else if (go && is_setp && pres[i]) begin
					pos_r <= sc;
				end
				if (go && is_off && pres[i]) off_r <= sc;
			end
		end

		assign pos_w[i] = pos_r;
		assign off_w[i] = off_r;
		assign at_w[i] = pos_r == tgt_r;
		assign step_w[i] = step_r;
		assign dir_w[i] = dir_r;
	end

	assign busy = state_r != ST_IDLE;
	assign stopped = stop_r;
	assign step_x = step_w[0];
	assign dir_x = dir_w[0];
	assign step_y = step_w[1];
	assign dir_y = dir_w[1];
endmodule

//--- tb/poi_interpreter_chk.sv
module poi_interpreter_checker
	import poi_pkg::*;
#(
	parameter logic [31:0] DWELL_CYC = 32'h00000004
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic servo_done,
	input wire logic busy,
	input wire logic stopped,
	input wire logic step_x,
	input wire logic dir_x,
	input wire logic step_y,
	input wire logic dir_y
);
	// Cycles since each axis last stepped
	logic [15:0] gap_x_r;
	logic [15:0] gap_y_r;
	// Accepted writes to control and instruction words
	wire logic wr_ctrl = psel && penable && pwrite && ce && paddr == 8'h00;
	wire logic wr_ins = psel && penable && pwrite && ce && !pslverr && paddr == 8'h14;
	// Gap counters saturate; reset starts them full
	always_ff @(posedge mclk) begin
		gap_x_r <= rst ? 16'hffff : step_x ? 16'h0000 : gap_x_r + {15'h0000, gap_x_r != 16'hffff};
		gap_y_r <= rst ? 16'hffff : step_y ? 16'h0000 : gap_y_r + {15'h0000, gap_y_r != 16'hffff};
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	step_gap_x_a: assert property (step_x |-> gap_x_r >= 16'h04e0)
		else $error("x steps faster than 200 kHz");
	step_gap_y_a: assert property (step_y |-> gap_y_r >= 16'h04e0)
		else $error("y steps faster than 200 kHz");
	step_busy_a: assert property ((step_x || step_y) |-> busy || $past(busy))
		else $error("step while idle");
	stop_still_a: assert property (stopped |-> !step_x && !step_y)
		else $error("step while stopped");
	stop_cause_a: assert property ($rose(stopped) |-> !$past(servo_done, 2))
		else $error("stop although servo was done");
	stop_hold_a: assert property (stopped && !wr_ctrl |=> stopped)
		else $error("stop released without clear");
	stop_idle_a: assert property (stopped && $past(stopped) |-> !busy)
		else $error("busy while stopped");
	start_busy_a: assert property (wr_ins |=> busy)
		else $error("instruction not started");
	// Main scenarios reached
	cover property (step_x && busy);
	cover property ($rose(stopped));
	cover property ($fell(busy) && !stopped);
endmodule

bind poi_interpreter poi_interpreter_checker #(.DWELL_CYC(DWELL_CYC)) mon (.mclk(mclk), .rst(rst), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .servo_done(servo_done), .busy(busy), .stopped(stopped),
	.step_x(step_x), .dir_x(dir_x), .step_y(step_y), .dir_y(dir_y));

//--- tb/poi_servo_model.sv
module poi_servo_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic step_x,
	input wire logic step_y,
	input wire logic mute,
	output logic servo_done
);
	timeunit 1ns;
	timeprecision 1ps;
	// Quiet cycles since the last pulse
	logic [7:0] quiet_r;
	// Every pulse restarts settling of the amplifier
	always_ff @(posedge mclk) begin
		if (rst || step_x || step_y) quiet_r <= 8'h00;
		else if (quiet_r != 8'hff) quiet_r <= quiet_r + 8'h01;
	end
	// In position after ten quiet cycles; mute is a stuck amplifier
	assign servo_done = !mute && quiet_r >= 8'h0a;
endmodule

//--- tb/test_poi_interpreter.sv
module test_poi_interpreter;
	timeunit 1ns;
	timeprecision 1ps;
	// Bench-driven inputs
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic mute = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	// Design outputs and captured answers
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, servo_done, busy, stopped, step_x, dir_x, step_y, dir_y, err;
	// Counters
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	int nx = 0;
	int ny = 0;
	int nb = 0;
	int sb;
	int sx;
	int sy;
	// Short dwell unit keeps the run brief
	poi_interpreter #(.DWELL_CYC(32'h00000004)) dut (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .servo_done(servo_done), .busy(busy), .stopped(stopped), .step_x(step_x),
		.dir_x(dir_x), .step_y(step_y), .dir_y(dir_y));
	poi_servo_model amp (.mclk(mclk), .rst(rst), .step_x(step_x), .step_y(step_y), .mute(mute),
		.servo_done(servo_done));
	initial forever #2 mclk = ~mclk;
	// Step counts and run limit
	always @(posedge mclk) begin
		nx <= nx + int'(step_x);
		ny <= ny + int'(step_y);
		nb <= nb + int'(busy);
		cyc <= cyc + 1;
		if (cyc == 100000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; holds until pready at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	function automatic logic [31:0] lit(input logic [20:0] v);
		return {11'h400, v};
	endfunction
	function automatic logic [31:0] opr(input logic [1:0] m, input logic ix, input logic [3:0] s, input logic [12:0] r);
		return {1'b1, m, ix, s, 11'h000, r};
	endfunction
	// Load operands, start, wait for idle and trailing pulses
	task automatic run(input logic [31:0] ins, input logic [31:0] ox, input logic [31:0] of);
		wr(8'h18, ox);
		wr(8'h1c, 32'h00000000);
		wr(8'h20, of);
		sx = nx;
		sy = ny;
		wr(8'h14, ins);
		repeat (2) @(negedge mclk);
		do @(negedge mclk); while (busy !== 1'b0);
		repeat (2) @(negedge mclk);
	endtask
	task automatic mv(input int ex, input int ey);
		compare("steps_x", ex, nx - sx);
		compare("steps_y", ey, ny - sy);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		compare(what, exp, rd);
	endtask
	// Drive on X only, speed left out
	task automatic t_drive;
		run(32'h0000005b, 32'h00000000, 32'h00000000);
		run(32'h00000000, lit(21'h000003), 32'h00000000);
		mv(3, 0);
		rdchk("speed", 8'h38, 32'h00030d40);
		rdchk("pos_x", 8'h30, 32'h00000003);
	endtask
	// Indexed single and double register operands
	task automatic t_index;
		wr(8'h24, 32'h0000001e);
		wr(8'h28, 32'h00000002);
		wr(8'h88, 32'h0000000a);
		run(32'h00000000, opr(2'h1, 1'b1, 4'h2, 13'h0014), lit(21'h030d40));
		mv(2, 0);
		wr(8'h24, 32'h00000028);
		wr(8'h28, 32'h0000ffff);
		wr(8'h24, 32'h00000029);
		wr(8'h28, 32'h0000ffff);
		wr(8'ha4, 32'h00000028);
		run(32'h00000000, opr(2'h2, 1'b1, 4'h9, 13'h0000), 32'h00000000);
		mv(1, 0);
		compare("dir_x", 32'h00000001, {31'h0, dir_x});
	endtask
	// Modal addressing and code omission
	task automatic t_modal;
		run(32'h0000005a, 32'h00000000, 32'h00000000);
		apb(1'b0, 8'h2c, 32'h00000000);
		compare("absolute_mode", 32'h00000001, {31'h0, rd[4]});
		run(32'h00000100, lit(21'h000006), 32'h00000000);
		mv(2, 0);
		run(32'h0000005b, 32'h00000000, 32'h00000000);
		run(32'h00000100, lit(21'h000002), 32'h00000000);
		mv(2, 0);
		run(32'h00000049, lit(21'h000001), 32'h00000000);
		run(32'h00000000, lit(21'h000002), 32'h00000000);
		mv(3, 0);
		run(32'h00000000, lit(21'h000002), 32'h00000000);
		mv(3, 0);
		run(32'h00000049, lit(21'h000000), 32'h00000000);
	endtask
	// Dwell of two units, then a dwell without its count
	task automatic t_dwell;
		sb = nb;
		run(32'h00000004, lit(21'h000002), 32'h00000000);
		compare("dwell_cycles", 32'h0000000c, nb - sb);
		run(32'h00000004, 32'h00000000, 32'h00000000);
		apb(1'b0, 8'h2c, 32'h00000000);
		compare("op_err_dwell", 32'h00000001, {31'h0, rd[1]});
		wr(8'h00, 32'h00000003);
	endtask
	// Refused operands, then unit scaling
	task automatic t_bad;
		wr(8'h08, 32'h000003e8);
		run(32'h00000000, lit(21'h000001), lit(21'h0007d0));
		mv(0, 0);
		apb(1'b0, 8'h2c, 32'h00000000);
		compare("op_err_speed", 32'h00000001, {31'h0, rd[1]});
		wr(8'h00, 32'h00000003);
		wr(8'h08, 32'h00030d40);
		run(32'h00000000, opr(2'h1, 1'b0, 4'h0, 13'h1b58), 32'h00000000);
		mv(0, 0);
		apb(1'b0, 8'h2c, 32'h00000000);
		compare("op_err_reg", 32'h00000001, {31'h0, rd[1]});
		wr(8'h00, 32'h00000003);
		wr(8'h04, 32'h00000003);
		run(32'h00000000, lit(21'h000001), 32'h00000000);
		mv(10, 0);
		wr(8'h04, 32'h00000000);
	endtask
	// Servo end check, timeout, disable, on demand
	task automatic t_servo;
		wr(8'h10, 32'h00000064);
		run(32'h00000200, lit(21'h000001), 32'h00000000);
		compare("stop_ok", 32'h00000000, {31'h0, stopped});
		mute <= 1'b1;
		run(32'h00000200, lit(21'h000001), 32'h00000000);
		compare("stop_timeout", 32'h00000001, {31'h0, stopped});
		apb(1'b0, 8'h2c, 32'h00000000);
		compare("err_code", 32'h00000fa2, {16'h0000, rd[31:16]});
		apb(1'b1, 8'h14, 32'h00000000);
		compare("instr_refused", 32'h00000001, {31'h0, err});
		wr(8'h00, 32'h00000003);
		wr(8'h10, 32'h00000000);
		run(32'h00000200, lit(21'h000001), 32'h00000000);
		compare("stop_skip", 32'h00000000, {31'h0, stopped});
		wr(8'h10, 32'h00000064);
		run(32'h00000009, 32'h00000000, 32'h00000000);
		compare("stop_settle", 32'h00000001, {31'h0, stopped});
		wr(8'h00, 32'h00000003);
		mute <= 1'b0;
	endtask
	task automatic report_and_stop;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Reset, then the scenarios in turn
	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		t_drive();
		t_index();
		t_modal();
		t_dwell();
		t_bad();
		t_servo();
		report_and_stop();
	end
endmodule
